/* hdl/rfa_arbiter.sv */
// RF and I2C access arbiter: config bits, RF gating, arbitration, write wakeup
`timescale 1ns/1ps
`include "rfa_regs.svh"
module rfa_arbiter
    import rfa_pkg::*;
#(
    parameter int ACK_LEN_W = 5
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 rf_link_clk_in,
    input  wire logic                 rf_cmd_done_in,
    input  wire rfa_rf_cmd_type       rf_cmd_kind_in,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    input  wire logic                 wired_supply_input_in,
    input  wire logic                 nvm_busy_in,
    input  wire logic                 reply_busy_in,
    input  wire logic                 cfg_wr_in,
    input  wire logic [7:0]           cfg_addr_in,
    input  wire logic [7:0]           cfg_wdata_in,
    input  wire logic [7:0]           cfg_rd_addr_in,
    output logic      [7:0]           cfg_rdata_out,
    output rfa_state_type             state_out,
    output logic                      i2c_grant_out,
    output logic                      i2c_commit_out,
    output logic                      rf_cmd_accept_out,
    output rfa_rf_cmd_type            rf_cmd_exec_out,
    output logic      [1:0]           rf_port_enable_out,
    output logic      [ACK_LEN_W-1:0] ack_words_out,
    output logic                      umi_to_reader_out,
    output logic                      xi_to_reader_out,
    output logic                      scl_out,
    output logic                      scl_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    rfa_state_type  state;
    rfa_cfg_type    cfg;
    rfa_rf_cmd_type link_cmd;
    logic           link_tog;
    logic           tog_s;
    logic           tog_d;
    logic           rf_evt;
    logic [2:0]     pins_s;
    logic           scl_s;
    logic           sda_s;
    logic           supply_s;
    logic           scl_d;
    logic           sda_d;
    logic           start_det;
    logic           stop_det;
    logic           scl_rise;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic [7:0]     full_byte;
    logic           first_byte;
    logic           byte_done;
    logic           addr_hit;
    logic           addr_miss;
    logic [1:0]     data_bytes;
    logic           i2c_rw;
    logic           i2c_wrote;
    logic           i2c_exit;
    logic [7:0]     settle;
    logic           internal_done;
    logic           go_internal_rf;
    logic           go_internal_i2c;
    logic           rf_writing;
    logic           kill;
    logic           rf_blocked_all;
    logic [1:0]     port_en;
    logic           rf_any;
    logic           cfg_wr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: command completion as a toggle, kind held beside it

    // Kind stays stable until the next command, so the toggle qualifies it
    always_ff @(posedge rf_link_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            link_tog <= 1'b0;
            link_cmd <= '0;
        end
        else if (rf_cmd_done_in)
        begin
            link_tog <= ~link_tog;
            link_cmd <= rf_cmd_kind_in;
        end
    end

    rfa_sync #(
        .WIDTH     (1),
        .RESET_VAL (8'h00)
    ) u_tog_sync (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .async_in (link_tog),
        .sync_out (tog_s)
    );

    // Pins idle high on an I2C bus
    rfa_sync #(
        .WIDTH     (3),
        .RESET_VAL (8'h03)
    ) u_pin_sync (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .async_in ({wired_supply_input_in, sda_in, scl_in}),
        .sync_out (pins_s)
    );

    assign scl_s    = pins_s[0];
    assign sda_s    = pins_s[1];
    assign supply_s = pins_s[2];

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tog_d <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            tog_d <= tog_s;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign rf_evt = tog_s ^ tog_d;

    ////////////////////////////////////////////////////////////////////////////
    // I2C bus watcher: start, stop, slave address

    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise  = scl_s & ~scl_d;
    assign byte_done = scl_rise & (bit_cnt == 4'h7);
    assign full_byte = {shift[6:0], sda_s};
    // No supply means no powered master on the bus
    assign addr_hit  = byte_done & first_byte & supply_s & (full_byte[7:1] == `RFA_SLAVE_ADDR);
    assign addr_miss = byte_done & first_byte & ~(supply_s & (full_byte[7:1] == `RFA_SLAVE_ADDR));

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            first_byte <= 1'b0;
        end
        else if (start_det)
        begin
            bit_cnt    <= 4'h0;
            first_byte <= 1'b1;
        end
        else if (stop_det)
        begin
            bit_cnt    <= 4'h0;
            first_byte <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (bit_cnt == 4'h8)
            begin
                bit_cnt    <= 4'h0;
                first_byte <= 1'b0;
            end
            else
            begin
                shift   <= full_byte;
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // Pointer byte plus one data byte means a memory write was commanded
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            data_bytes <= 2'h0;
            i2c_rw     <= 1'b1;
        end
        else if (addr_hit && state != RFA_ST_I2C)
        begin
            data_bytes <= 2'h0;
            i2c_rw     <= full_byte[0];
        end
        else if (addr_hit)
        begin
            i2c_rw <= full_byte[0];
        end
        else if (state == RFA_ST_I2C && byte_done && !first_byte && data_bytes != 2'h2)
        begin
            data_bytes <= data_bytes + 2'h1;
        end
    end

    assign i2c_wrote = ~i2c_rw & (data_bytes == 2'h2);
    // A held-low SCL produces no stop, so the I2C hold lasts until supply is removed
    assign i2c_exit  = stop_det | addr_miss | ~supply_s;

    ////////////////////////////////////////////////////////////////////////////
    // RF access gating

    assign kill           = cfg.kill_byte[`RFA_KILL_BIT];
    assign rf_blocked_all = kill
                          | (supply_s & ~cfg.rfctl_byte[`RFA_RF_ALLOWED_BIT]);
    assign port_en[0]     = ~rf_blocked_all & ~cfg.rfctl_byte[`RFA_PORT1_DIS_BIT];
    assign port_en[1]     = ~rf_blocked_all & ~cfg.rfctl_byte[`RFA_PORT2_DIS_BIT];
    assign rf_any         = |port_en;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rf_port_enable_out <= 2'h0;
        end
        else
        begin
            rf_port_enable_out <= port_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    assign internal_done   = (settle == 8'h00) & ~nvm_busy_in & ~reply_busy_in;
    // Address match beats a same-cycle RF completion
    assign go_internal_rf  = (state == RFA_ST_IDLE) & ~addr_hit & rf_evt & rf_any;
    assign go_internal_i2c = (state == RFA_ST_I2C) & i2c_exit & i2c_wrote;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= RFA_ST_INTERNAL;
        end
        else
        begin
            unique case (state)
                RFA_ST_INTERNAL:
                begin
                    // I2C and RF both ignored here
                    if (internal_done)
                    begin
                        state <= RFA_ST_IDLE;
                    end
                end
                RFA_ST_I2C:
                begin
                    // RF completions are dropped in this state
                    if (i2c_exit)
                    begin
                        state <= i2c_wrote ? RFA_ST_INTERNAL : RFA_ST_IDLE;
                    end
                end
                RFA_ST_IDLE:
                begin
                    if (addr_hit)
                    begin
                        state <= RFA_ST_I2C;
                    end
                    else if (go_internal_rf)
                    begin
                        state <= RFA_ST_INTERNAL;
                    end
                end
            endcase
        end
    end

    // Minimum stay lets the busy inputs rise before they are trusted
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            settle <= `RFA_INIT_CYCLES;
        end
        else if (go_internal_rf || go_internal_i2c)
        begin
            settle <= `RFA_EXEC_SETTLE;
        end
        else if (state == RFA_ST_INTERNAL && settle != 8'h00)
        begin
            settle <= settle - 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rf_cmd_accept_out <= 1'b0;
            rf_cmd_exec_out   <= '0;
            i2c_commit_out    <= 1'b0;
        end
        else
        begin
            rf_cmd_accept_out <= go_internal_rf;
            rf_cmd_exec_out   <= go_internal_rf ? link_cmd : '0;
            i2c_commit_out    <= go_internal_i2c;
        end
    end

    assign state_out     = state;
    assign i2c_grant_out = (state == RFA_ST_I2C);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration bytes

    assign cfg_wr_ok = cfg_wr_in & (state == RFA_ST_I2C);

    // Only the I2C side writes these; RF may set kill only
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg.kill_byte  <= `RFA_KILL_BYTE_RESET;
            cfg.rfctl_byte <= `RFA_RFCTL_BYTE_RESET;
            cfg.ack_byte   <= `RFA_ACK_BYTE_RESET;
        end
        else
        begin
            if (cfg_wr_ok && cfg_addr_in == `RFA_CFG_KILL_BYTE)
            begin
                cfg.kill_byte <= cfg_wdata_in;
            end
            // Set wins over a clear in the same cycle
            if (go_internal_rf && link_cmd.kill)
            begin
                cfg.kill_byte[`RFA_KILL_BIT] <= 1'b1;
            end
            if (cfg_wr_ok && cfg_addr_in == `RFA_CFG_RFCTL_BYTE)
            begin
                cfg.rfctl_byte <= cfg_wdata_in;
            end
            if (cfg_wr_ok && cfg_addr_in == `RFA_CFG_ACK_BYTE)
            begin
                cfg.ack_byte <= cfg_wdata_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_rdata_out     <= 8'h00;
            ack_words_out     <= '0;
            umi_to_reader_out <= 1'b0;
        end
        else
        begin
            unique case (cfg_rd_addr_in)
                `RFA_CFG_KILL_BYTE:  cfg_rdata_out <= cfg.kill_byte;
                `RFA_CFG_RFCTL_BYTE: cfg_rdata_out <= cfg.rfctl_byte;
                `RFA_CFG_ACK_BYTE:   cfg_rdata_out <= cfg.ack_byte;
                default:             cfg_rdata_out <= 8'h00;
            endcase
            ack_words_out     <= ACK_LEN_W'(cfg.ack_byte[`RFA_ACK_LEN_MSB:`RFA_ACK_LEN_LSB]);
            umi_to_reader_out <= cfg.ack_byte[`RFA_UMI_BIT];
        end
    end

    // Stored XI bit is never shown to the reader
    assign xi_to_reader_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Write wakeup on the serial clock line

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rf_writing <= 1'b0;
        end
        else if (go_internal_rf)
        begin
            rf_writing <= link_cmd.write;
        end
        else if (state == RFA_ST_INTERNAL && internal_done)
        begin
            rf_writing <= 1'b0;
        end
    end

    // Only while asleep; with supply present the host owns SCL
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scl_oe_out <= 1'b0;
        end
        else
        begin
            scl_oe_out <= cfg.rfctl_byte[`RFA_WAKEUP_EN_BIT] & ~supply_s & rf_writing & nvm_busy_in;
        end
    end

    assign scl_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_rf_done_idle;
        (state == RFA_ST_IDLE) && rf_evt && rf_any && !addr_hit;
    endsequence

    sequence s_i2c_release_write;
        (state == RFA_ST_I2C) && stop_det && i2c_wrote;
    endsequence

    a_i2c_entry_taken: assert property ((state == RFA_ST_IDLE) && addr_hit |=> (state == RFA_ST_I2C))
        else $error("Address match in idle did not grant I2C");

    a_internal_blocks_i2c: assert property ((state == RFA_ST_INTERNAL) && addr_hit |=> (state != RFA_ST_I2C))
        else $error("I2C granted during internal control");

    a_rf_cmd_executes: assert property (s_rf_done_idle |=> rf_cmd_accept_out && (state == RFA_ST_INTERNAL))
        else $error("RF command not taken into internal control");

    a_i2c_drops_rf: assert property ((state == RFA_ST_I2C) && rf_evt |=> !rf_cmd_accept_out)
        else $error("RF command accepted under I2C control");

    a_i2c_write_exit: assert property (s_i2c_release_write |=> (state == RFA_ST_INTERNAL) && i2c_commit_out)
        else $error("I2C write release did not enter internal control");

    a_kill_blocks_rf: assert property (kill |=> rf_port_enable_out == 2'h0)
        else $error("Antenna port enabled while killed");

    a_supply_blocks_rf: assert property (supply_s && !cfg.rfctl_byte[`RFA_RF_ALLOWED_BIT]
        |=> rf_port_enable_out == 2'h0 && !rf_cmd_accept_out)
        else $error("RF enabled with supply present and RF disallowed");

    a_port1_disable: assert property (!rf_blocked_all && cfg.rfctl_byte[`RFA_PORT1_DIS_BIT] |=> !rf_port_enable_out[0])
        else $error("Disabled antenna port one still enabled");

    a_kill_clear: assert property (cfg_wr_ok && cfg_addr_in == `RFA_CFG_KILL_BYTE && !cfg_wdata_in[`RFA_KILL_BIT] && !go_internal_rf |=> !kill ##1 (rf_port_enable_out != 2'h0 || rf_blocked_all || cfg.rfctl_byte[1:0] == 2'h3))
        else $error("Kill bit not cleared by I2C write");

    a_ack_len_write: assert property (cfg_wr_ok && cfg_addr_in == `RFA_CFG_ACK_BYTE |=> ##1 ack_words_out == ACK_LEN_W'($past(cfg_wdata_in, 2)))
        else $error("Ack length not taken from byte write");

    a_wakeup_drive: assert property (cfg.rfctl_byte[`RFA_WAKEUP_EN_BIT] && !supply_s
        && rf_writing && nvm_busy_in |=> scl_oe_out && !scl_out)
        else $error("SCL not driven low during RF write wakeup");

endmodule : rfa_arbiter

/* include/rfa_regs.svh */
// Constants for the RF and I2C access arbiter: offsets, fields, reset values, timing
`ifndef RFA_REGS_SVH
`define RFA_REGS_SVH

// Configuration byte offsets
`define RFA_CFG_KILL_BYTE     8'h09
`define RFA_CFG_RFCTL_BYTE    8'h15
`define RFA_CFG_ACK_BYTE      8'h16

// Byte 9 fields
`define RFA_KILL_BIT          2

// Byte 21 fields
`define RFA_PORT1_DIS_BIT     0
`define RFA_PORT2_DIS_BIT     1
`define RFA_RF_ALLOWED_BIT    3
`define RFA_WAKEUP_EN_BIT     6

// Byte 22 fields
`define RFA_ACK_LEN_LSB       0
`define RFA_ACK_LEN_MSB       4
`define RFA_UMI_BIT           5
`define RFA_XI_BIT            6

// Factory values
`define RFA_KILL_BYTE_RESET   8'h00
`define RFA_RFCTL_BYTE_RESET  8'h00
`define RFA_ACK_BYTE_RESET    8'h06

// Timing counts in core clock cycles
`define RFA_INIT_CYCLES       8'h10
`define RFA_EXEC_SETTLE       8'h02

// I2C slave address
`define RFA_SLAVE_ADDR        7'h6E

`endif

/* include/rfa_pkg.sv */
// Types shared by the RF and I2C access arbiter
package rfa_pkg;

    typedef enum logic [1:0] {
        RFA_ST_INTERNAL,
        RFA_ST_I2C,
        RFA_ST_IDLE
    } rfa_state_type;

    // Kind of a fully received RF command
    typedef struct packed {
        logic kill;
        logic write;
    } rfa_rf_cmd_type;

    // Configuration bytes held by the arbiter
    typedef struct packed {
        logic [7:0] kill_byte;
        logic [7:0] rfctl_byte;
        logic [7:0] ack_byte;
    } rfa_cfg_type;

endpackage : rfa_pkg

/* hdl/rfa_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rfa_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage_one <= RESET_VAL[WIDTH-1:0];
            sync_out  <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule : rfa_sync

/* dv/rfa_host_model.sv */
// Host microcontroller and reader model for the access arbiter
`timescale 1ns/1ps
module rfa_host_model
    import rfa_pkg::*;
(
    input  wire logic      ref_clk_in,
    output logic           scl_out,
    output logic           sda_out,
    output logic           link_clk_out,
    output logic           cmd_done_out,
    output rfa_rf_cmd_type cmd_kind_out
);
    // Lines idle high, link clock still outside frames
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        link_clk_out = 1'b0;
        cmd_done_out = 1'b0;
        cmd_kind_out = 2'h0;
    end
    task wt(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wt
    task bit_out(input logic b);
        sda_out = b;
        wt(2);
        scl_out = 1'b1;
        wt(4);
        scl_out = 1'b0; // Left low: a pause here stalls the bus
        wt(2);
    endtask : bit_out
    task start;
        sda_out = 1'b1;
        scl_out = 1'b1;
        wt(4);
        sda_out = 1'b0;
        wt(4);
        scl_out = 1'b0;
        wt(2);
    endtask : start
    task stop;
        sda_out = 1'b0;
        wt(2);
        scl_out = 1'b1;
        wt(4);
        sda_out = 1'b1;
        wt(4);
    endtask : stop
    // MSB first, then a released acknowledge slot
    task put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            bit_out(b[i]);
        bit_out(1'b1);
    endtask : put_byte
    // One frame: done for one link cycle, kind held until the next
    task rf_cmd(input rfa_rf_cmd_type k);
        // Random phase so the link clock is unrelated to the core clock
        #($urandom_range(40, 0));
        cmd_kind_out = k;
        cmd_done_out = 1'b1;
        #3 link_clk_out = 1'b1;
        #3 link_clk_out = 1'b0;
        cmd_done_out = 1'b0;
        #3 link_clk_out = 1'b1;
        #3 link_clk_out = 1'b0;
    endtask : rf_cmd
endmodule : rfa_host_model

/* dv/rfa_arbiter_tb.sv */
// Self-checking bench for the RF and I2C access arbiter
`timescale 1ns/1ps
module rfa_arbiter_tb
    import rfa_pkg::*;
;
    logic           ref_clk_in = 1'b0;
    logic           rst_in = 1'b1;
    logic           supply = 1'b0;
    logic           nvm_busy = 1'b0;
    logic           reply_busy = 1'b0;
    logic           cfg_wr = 1'b0;
    logic [7:0]     cfg_addr = 8'h00;
    logic [7:0]     cfg_wdata = 8'h00;
    logic [7:0]     rd_addr = 8'h00;
    logic           scl_drv, sda_drv, link_clk, done, grant, commit, accept, umi, xi, scl_o, scl_oe;
    rfa_rf_cmd_type kind, exec;
    rfa_state_type  st;
    logic [7:0]     rdata;
    logic [1:0]     pen;
    logic [4:0]     ackw;
    logic [7:0]     ack_len;
    logic [7:0]     exp_q[$];
    int             err_count = 0;
    int             checks = 0;
    wire logic      scl_wire = scl_drv & (~scl_oe | scl_o);
    ////////////////////////////////////////////////////////////////////////
    always #50 ref_clk_in = ~ref_clk_in;
    rfa_host_model hm (.ref_clk_in(ref_clk_in), .scl_out(scl_drv), .sda_out(sda_drv), .link_clk_out(link_clk),
        .cmd_done_out(done), .cmd_kind_out(kind));
    rfa_arbiter uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .rf_link_clk_in(link_clk), .rf_cmd_done_in(done),
        .rf_cmd_kind_in(kind), .scl_in(scl_wire), .sda_in(sda_drv), .wired_supply_input_in(supply),
        .nvm_busy_in(nvm_busy), .reply_busy_in(reply_busy), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
        .cfg_wdata_in(cfg_wdata), .cfg_rd_addr_in(rd_addr), .cfg_rdata_out(rdata), .state_out(st),
        .i2c_grant_out(grant), .i2c_commit_out(commit), .rf_cmd_accept_out(accept), .rf_cmd_exec_out(exec),
        .rf_port_enable_out(pen), .ack_words_out(ackw), .umi_to_reader_out(umi), .xi_to_reader_out(xi),
        .scl_out(scl_o), .scl_oe_out(scl_oe));
    ////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task test_done;
        check("pending", 8'h00, 8'(exp_q.size()));
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // Oldest note against each pulse; mid-cycle so registers have settled
    always @(negedge ref_clk_in)
        if (accept === 1'b1 || commit === 1'b1)
            check("event", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF, commit ? 8'h80 : {6'h00, exec});
    task wt(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wt
    task rf(input rfa_rf_cmd_type k, input logic taken);
        if (taken)
            exp_q.push_back({6'h00, k});
        hm.rf_cmd(k);
        wt(12);
    endtask : rf
    // Address, config byte through the engine port, pointer and data
    task i2c_wr(input logic [7:0] a, input logic [7:0] d);
        hm.start();
        hm.put_byte(8'hDC);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        wt(1);
        cfg_wr = 1'b0;
        hm.put_byte(a);
        hm.put_byte(d);
        exp_q.push_back(8'h80);
        hm.stop();
        wt(10);
    endtask : i2c_wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        rd_addr = a;
        wt(2);
        check("cfg_rdata", e, rdata);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        err_count++;
        test_done();
    end
    initial
    begin
        void'($urandom(83));
        ack_len = 8'($urandom_range(31, 0));
        wt(6);
        rst_in = 1'b0;
        wt(25);
        check("state", 8'(RFA_ST_IDLE), 8'(st));
        check("ack_words", 8'h06, {3'h0, ackw});
        check("port_en", 8'h03, {6'h00, pen});
        rf(2'b00, 1'b1);
        supply = 1'b1;
        wt(6);
        check("port_en", 8'h00, {6'h00, pen});
        rf(2'b01, 1'b0);
        i2c_wr(8'h15, 8'h09);
        check("port_en", 8'h02, {6'h00, pen});
        rf(2'b01, 1'b1);
        hm.start();
        hm.put_byte(8'hDD);
        check("grant", 8'h01, {7'h00, grant});
        rf(2'b01, 1'b0);
        hm.stop();
        wt(4);
        check("state", 8'(RFA_ST_IDLE), 8'(st));
        reply_busy = 1'b1;
        rf(2'b01, 1'b1);
        hm.start();
        hm.put_byte(8'hDC);
        check("grant", 8'h00, {7'h00, grant});
        hm.stop();
        reply_busy = 1'b0;
        wt(6);
        // Host retries once the reply is over
        hm.start();
        hm.put_byte(8'hDC);
        check("grant", 8'h01, {7'h00, grant});
        hm.stop();
        wt(6);
        rf(2'b10, 1'b1);
        check("port_en", 8'h00, {6'h00, pen});
        rd(8'h09, 8'h04);
        i2c_wr(8'h09, 8'h00);
        check("port_en", 8'h02, {6'h00, pen});
        i2c_wr(8'h16, {3'b011, ack_len[4:0]});
        check("ack_words", {3'h0, ack_len[4:0]}, {3'h0, ackw});
        check("umi", 8'h01, {7'h00, umi});
        check("xi", 8'h00, {7'h00, xi});
        rd(8'h16, {3'b011, ack_len[4:0]});
        rd(8'h20, 8'h00);
        // Wakeup armed, then supply removed
        i2c_wr(8'h15, 8'h48);
        supply = 1'b0;
        wt(6);
        nvm_busy = 1'b1;
        rf(2'b01, 1'b1);
        check("scl_oe", 8'h01, {7'h00, scl_oe});
        check("scl_line", 8'h00, {7'h00, scl_wire});
        nvm_busy = 1'b0;
        wt(6);
        check("scl_oe", 8'h00, {7'h00, scl_oe});
        test_done();
    end
endmodule : rfa_arbiter_tb
